//--- include/tpw_pkg.sv
package tpw_pkg;

    // operating mode field value that selects pulse width operation
    localparam logic [1:0]  MODE_PWM   = 2'h3;

    // count clock select codes
    localparam logic [1:0]  CLK_UNDIV  = 2'h0;
    localparam logic [1:0]  CLK_DIV8   = 2'h1;
    localparam logic [1:0]  CLK_DIV32  = 2'h2;
    localparam logic [1:0]  CLK_SUB32  = 2'h3;

    // divider terminal counts (divide by 8 and by 32)
    localparam logic [4:0]  DIV8_LAST  = 5'h07;
    localparam logic [4:0]  DIV32_LAST = 5'h1F;

    // periods: 65535 count clocks (16-bit), 255 prescaled ticks (8-bit)
    localparam logic [15:0] PER16_LAST = 16'hFFFE;
    localparam logic [7:0]  PER8_LAST  = 8'hFE;

    // reset value of reload and active width; interrupt level that disables the request
    localparam logic [15:0] RELOAD_RST = 16'h0000;
    localparam logic [2:0]  IRQ_OFF    = 3'h0;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT_TRIG,
        ST_RUN
    } tpw_state_t;

endpackage : tpw_pkg

//--- hdl/tpw_clk_div.sv
`timescale 1ns/1ps
// count clock enable: undivided, /8, /32 or sub-clock /32
module tpw_clk_div (
    input  wire logic       mclk,
    input  wire logic       rstn,
    input  wire logic       run,
    input  wire logic [1:0] sel,
    input  wire logic       subclk_tick,
    output logic            tick
);

    logic [4:0] div_cnt;

    // sub-clock source advances only on its own ticks
    wire       step      = (sel == tpw_pkg::CLK_SUB32) ? subclk_tick : 1'b1;
    wire [4:0] div_last  = (sel == tpw_pkg::CLK_DIV8) ? tpw_pkg::DIV8_LAST
                                                      : tpw_pkg::DIV32_LAST;
    wire       div_wrap  = step & (div_cnt == div_last);
    wire       next_tick = run & ((sel == tpw_pkg::CLK_UNDIV) | div_wrap);

    // cleared while stopped so the first period starts on a full tick
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            div_cnt <= 5'h00;
            tick    <= 1'b0;
        end else begin
            tick <= next_tick;
            if (!run || div_wrap)
                div_cnt <= 5'h00;
            else if (step)
                div_cnt <= div_cnt + 5'h01;
        end
    end

endmodule : tpw_clk_div

//--- hdl/tpw_channel.sv
`timescale 1ns/1ps
// Overview of operation
// - mode bit picks 16-bit sub-mode when clear, 8-bit when set
// - 16-bit period is fixed at 65535 count clocks
// - 16-bit output high for n count clocks each period
// - 8-bit upper byte sets high width in prescaled ticks
// - 8-bit lower byte m prescales by m+1; period 255 ticks
// - 8-bit high time is n times (m+1) count clocks
// - output repeats on its own once started
// - writes while counting go to reload; counter takes it next period
// - both operating mode bits set selects pulse width operation
// - pulse function bit must be set for pulse width operation
// - trigger source bit: start flag when clear, external edge when set
// - edge bit: falling edge when clear, rising edge when set
// - two-bit select picks undivided, /8, /32 or sub-clock /32
// - the channel start bit starts counting
// - every channel of this timer offers pulse width operation
module tpw_channel (
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic        op_mode_sel_lo,
    input  wire logic        op_mode_sel_hi,
    input  wire logic        pulse_func_sel,
    input  wire logic        trig_edge_sel,
    input  wire logic        trig_source_sel,
    input  wire logic        width_8bit_sel,
    input  wire logic        count_clk_sel_lo,
    input  wire logic        count_clk_sel_hi,
    input  wire logic        subclk_tick,
    input  wire logic        chan_start_bit,
    input  wire logic        ext_trigger_in,
    input  wire logic        chan_count_wr,
    input  wire logic [15:0] chan_count_wdata,
    input  wire logic [2:0]  chan_irq_level,
    output logic [15:0]      chan_count_rdata,
    output logic             pwm_out,
    output logic             irq_req,
    output logic             counting
);

    tpw_pkg::tpw_state_t state;
    tpw_pkg::tpw_state_t next_state;

    logic [15:0] reload;
    logic [15:0] act;
    logic        act_w8;
    logic [15:0] cnt;
    logic [7:0]  pre;
    logic        trig_prev;
    logic        tick;

    // mode decode: other timer modes are not this block's job
    wire pwm_en = ({op_mode_sel_hi, op_mode_sel_lo} == tpw_pkg::MODE_PWM)
                  & pulse_func_sel;
    wire go     = pwm_en & chan_start_bit;

    // trigger edges; input is already synchronous to mclk
    wire trig_rise = ext_trigger_in & ~trig_prev;
    wire trig_fall = ~ext_trigger_in & trig_prev;
    wire trig_fire = trig_edge_sel ? trig_rise : trig_fall;

    wire running   = (state == tpw_pkg::ST_RUN);
    wire enter_run = ((state == tpw_pkg::ST_IDLE) & go & ~trig_source_sel)
                   | ((state == tpw_pkg::ST_WAIT_TRIG) & go & trig_fire);

    // prescaler and period counter
    wire pre_wrap   = act_w8 ? (pre == act[7:0]) : 1'b1;
    wire per_last   = act_w8 ? (cnt[7:0] == tpw_pkg::PER8_LAST)
                             : (cnt == tpw_pkg::PER16_LAST);
    wire step       = running & tick & pre_wrap;
    wire period_end = step & per_last;
    wire high_now   = act_w8 ? (cnt[7:0] < act[15:8])
                             : (cnt < act);
    wire [1:0] clk_sel = {count_clk_sel_hi, count_clk_sel_lo};

    wire [15:0] next_cnt = !running   ? 16'h0000 :
                           period_end ? 16'h0000 :
                           step       ? cnt + 16'h0001 : cnt;
    wire [7:0]  next_pre = (!running || (tick && pre_wrap)) ? 8'h00 :
                           tick ? pre + 8'h01 : pre;

    // divider follows the next state, so the first count clock after start is a full one
    wire run_next = (next_state == tpw_pkg::ST_RUN);

    tpw_clk_div u_clk_div (
        .mclk        (mclk),
        .rstn        (rstn),
        .run         (run_next),
        .sel         (clk_sel),
        .subclk_tick (subclk_tick),
        .tick        (tick)
    );

    // channel sequencing
    always_comb begin
        next_state = state;
        case (state)
            tpw_pkg::ST_IDLE: begin
                if (go)
                    next_state = trig_source_sel ? tpw_pkg::ST_WAIT_TRIG
                                                 : tpw_pkg::ST_RUN;
            end
            tpw_pkg::ST_WAIT_TRIG: begin
                if (!go)
                    next_state = tpw_pkg::ST_IDLE;
                else if (trig_fire)
                    next_state = tpw_pkg::ST_RUN;
            end
            tpw_pkg::ST_RUN: begin
                if (!go)
                    next_state = tpw_pkg::ST_IDLE;
            end
            default: next_state = tpw_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state     <= tpw_pkg::ST_IDLE;
            trig_prev <= 1'b0;
        end else begin
            state     <= next_state;
            trig_prev <= ext_trigger_in;
        end
    end

    // software writes land only in reload; never disturb a live period
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn)
            reload <= tpw_pkg::RELOAD_RST;
        else if (chan_count_wr)
            reload <= chan_count_wdata;
    end

    // active width and sub-mode change only at a period boundary
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            act    <= tpw_pkg::RELOAD_RST;
            act_w8 <= 1'b0;
        end else if (enter_run || period_end) begin
            act    <= reload;
            act_w8 <= width_8bit_sel;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cnt <= 16'h0000;
            pre <= 8'h00;
        end else begin
            cnt <= next_cnt;
            pre <= next_pre;
        end
    end

    // outputs; readback mid-count is only a snapshot
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pwm_out          <= 1'b0;
            irq_req          <= 1'b0;
            counting         <= 1'b0;
            chan_count_rdata <= 16'h0000;
        end else begin
            pwm_out          <= running & high_now;
            irq_req          <= period_end & (chan_irq_level != tpw_pkg::IRQ_OFF);
            counting         <= running;
            chan_count_rdata <= running ? cnt : reload;
        end
    end

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    a_idle_out_low: assert property (!running |=> !pwm_out)
        else $error("output high while channel not running");
    a_mode_gate: assert property (!pwm_en |=> state == tpw_pkg::ST_IDLE)
        else $error("channel active outside pulse width mode");
    a_func_gate: assert property (!pulse_func_sel |=> !running
                                  ##1 (!counting && !pwm_out))
        else $error("channel ran with pulse function bit clear");
    a_period16_wrap: assert property (running && !act_w8 && tick
                                      && cnt == tpw_pkg::PER16_LAST && go |=> cnt == 16'h0000)
        else $error("16-bit period did not wrap at 65535");
    a_width16_out: assert property (running && go && !act_w8 && cnt == 16'h0000
                                    && act != 16'h0000 |=> pwm_out)
        else $error("16-bit period did not start high");
    a_prescale8: assert property (running && act_w8 && tick && pre == act[7:0]
                                  && go |=> pre == 8'h00)
        else $error("8-bit prescaler did not wrap at m");
    a_reload_only: assert property (running && !period_end && go |=> act == $past(act))
        else $error("active width changed mid-period");
    a_irq_level: assert property (irq_req |-> $past(chan_irq_level) != tpw_pkg::IRQ_OFF
                                  && $past(period_end))
        else $error("interrupt without period end or with level zero");
    a_trig_wait: assert property (state == tpw_pkg::ST_WAIT_TRIG && go && !trig_fire
                                  |=> state == tpw_pkg::ST_WAIT_TRIG)
        else $error("external start without selected edge");
    a_trig_start: assert property (state == tpw_pkg::ST_WAIT_TRIG && go && trig_fire
                                   |=> running ##1 counting)
        else $error("selected edge did not start the channel");

    c_period16: cover property (period_end && !act_w8);
    c_period8: cover property (period_end && act_w8);
    c_ext_start: cover property (state == tpw_pkg::ST_WAIT_TRIG ##1 running);
    c_reload_mid: cover property (running && chan_count_wr ##[1:1000] period_end);

endmodule : tpw_channel

//--- dv/tpw_far_end.sv
`timescale 1ns/1ps
// far side of the channel: sub-clock source and external trigger line
module tpw_far_end (
    input  wire logic mclk,
    input  wire logic rstn,
    input  wire logic trig_lvl,
    output logic      subclk_tick,
    output logic      ext_trigger_in
);
    // sub-clock at half the main rate; trigger moves only on mclk edges
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            subclk_tick    <= 1'h0;
            ext_trigger_in <= 1'h0;
        end else begin
            subclk_tick    <= ~subclk_tick;
            ext_trigger_in <= trig_lvl;
        end
    end
endmodule : tpw_far_end

//--- dv/timer_pulse_width_mode_test.sv
`timescale 1ns/1ps
module timer_pulse_width_mode_test;
    logic        mclk = 0, rstn = 0, w8 = 0, edg = 0, src = 0, go = 0, wr = 0, trig = 0;
    logic        md_hi = 1, md_lo = 1, pf = 1, cs_hi = 0, cs_lo = 0;
    logic [15:0] wd = 16'h0000;
    logic [2:0]  lvl = 3'h0;
    logic [15:0] rd;
    logic        pwm, irq, cnt, subt, ext;
    int          errors = 0, cmp_count = 0, irqs = 0, i0;

    tpw_channel tpw_channel_inst (.mclk(mclk), .rstn(rstn), .op_mode_sel_lo(md_lo),
        .op_mode_sel_hi(md_hi), .pulse_func_sel(pf), .trig_edge_sel(edg),
        .trig_source_sel(src), .width_8bit_sel(w8), .count_clk_sel_lo(cs_lo),
        .count_clk_sel_hi(cs_hi), .subclk_tick(subt), .chan_start_bit(go),
        .ext_trigger_in(ext), .chan_count_wr(wr), .chan_count_wdata(wd),
        .chan_irq_level(lvl), .chan_count_rdata(rd), .pwm_out(pwm), .irq_req(irq),
        .counting(cnt));
    tpw_far_end tpw_far_end_inst (.mclk(mclk), .rstn(rstn), .trig_lvl(trig),
        .subclk_tick(subt), .ext_trigger_in(ext));

    always #25 mclk = ~mclk;
    // irq pulses are one cycle wide, so count them at every edge
    always @(posedge mclk) if (irq === 1'b1) irqs <= irqs + 1;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
        end
    endtask : chk
    task automatic final_report;
        if (errors == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : final_report
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask : cyc
    // load while stopped, read the reload back, then start
    task automatic setup(input logic b8, input logic [1:0] cs, input logic [15:0] d);
        @(posedge mclk);
        w8 <= b8;
        {cs_hi, cs_lo} <= cs;
        wr <= 1;
        wd <= d;
        @(posedge mclk);
        wr <= 0;
        cyc(2);
        chk(rd, {16'h0000, d});
        go <= 1;
    endtask : setup
    task automatic stop;
        @(posedge mclk);
        go <= 0;
        cyc(4);
        chk(pwm, 1'b0);
        chk(cnt, 1'b0);
    endtask : stop
    // high time and rise-to-rise span in mclk cycles; per 0 skips the span
    task automatic measure(input int hi, input int per);
        int t, h, p;
        t = 0;
        while (pwm !== 1'b1 && t < 300) begin
            cyc(1);
            t++;
        end
        h = 0;
        while (pwm === 1'b1 && h < 70000) begin
            h++;
            cyc(1);
        end
        chk(h, hi);
        if (per != 0) begin
            p = h;
            while (pwm !== 1'b1 && p < 70000) begin
                p++;
                cyc(1);
            end
            chk(p, per);
        end
    endtask : measure

    task automatic t_mode;
        logic [2:0] bad [3] = '{3'h3, 3'h5, 3'h6};
        foreach (bad[i]) begin
            {md_hi, md_lo, pf} <= bad[i];
            setup(1, 2'h0, 16'h0201);
            cyc(20);
            chk(pwm, 1'b0);
            stop();
        end
        {md_hi, md_lo, pf} <= 3'h7;
    endtask : t_mode
    task automatic t_16;
        setup(0, 2'h0, 16'h0003);
        measure(3, 65535);
        chk(cnt, 1'b1);
        stop();
    endtask : t_16
    // new width written mid-run shows only from the following period
    task automatic t_8;
        lvl <= 3'h3;
        setup(1, 2'h0, 16'h0201);
        i0 = irqs;
        @(posedge mclk);
        // plain overwrite while counting; the count is never read back and modified
        wr <= 1;
        wd <= 16'h0501;
        @(posedge mclk);
        wr <= 0;
        measure(4, 510);
        measure(10, 510);
        chk(irqs - i0, 2);
        lvl <= 3'h0;
        i0 = irqs;
        measure(10, 510);
        measure(10, 510);
        chk(irqs - i0, 0);
        stop();
    endtask : t_8
    // /8, /32 and sub-clock /32 (sub-clock ticks every second cycle)
    task automatic t_div;
        int hi [3] = '{8, 32, 64};
        foreach (hi[i]) begin
            // start on a known sub-clock phase, else the first sub-clock tick may be short
            while (subt !== 1'b1)
                cyc(1);
            setup(1, 2'(i + 1), 16'h0100);
            measure(hi[i], 0);
            stop();
        end
    endtask : t_div
    // wrong edge first, then the selected one
    task automatic t_trig(input logic e);
        @(posedge mclk);
        trig <= e;
        src <= 1;
        edg <= e;
        setup(1, 2'h0, 16'h0201);
        cyc(3);
        trig <= ~e;
        cyc(20);
        chk(pwm, 1'b0);
        trig <= e;
        measure(4, 0);
        stop();
        src <= 0;
    endtask : t_trig

    initial begin
        cyc(16);
        rstn <= 1;
        cyc(2);
        chk(pwm, 1'b0);
        t_mode();
        t_16();
        t_8();
        t_div();
        t_trig(1);
        t_trig(0);
        final_report();
    end
    // about 70k cycles are needed; cut off at 100k
    initial begin
        #5000000;
        errors++;
        final_report();
    end
endmodule : timer_pulse_width_mode_test
